// ===== logic/fsl_pkg.sv
// Constants, register map and decode tables for the fan speed loop register bank
package fsl_pkg;

    localparam int unsigned FSL_NUM_CH = 4;

    // Register offsets
    localparam logic [7:0] FSL_ADDR_HIGH_STATUS = 8'h24;
    localparam logic [7:0] FSL_ADDR_LIMIT_EXT1 = 8'h30;
    localparam logic [7:0] FSL_ADDR_LIMIT_EXT2 = 8'h31;
    localparam logic [7:0] FSL_ADDR_LIMIT_EXT3 = 8'h32;
    localparam logic [7:0] FSL_ADDR_LIMIT_LOCAL = 8'h34;
    localparam logic [7:0] FSL_ADDR_FAN_DRIVE = 8'h40;
    localparam logic [7:0] FSL_ADDR_FAN_CONFIG = 8'h42;

    // Reset values
    localparam logic [7:0] FSL_LIMIT_RESET = 8'h55;
    localparam logic [7:0] FSL_DRIVE_RESET = 8'h00;
    localparam logic [7:0] FSL_CONFIG_RESET = 8'h2b;
    localparam logic [7:0] FSL_ZERO = 8'h00;

    // Configuration field positions
    localparam int unsigned FSL_CFG_LOOP_EN_BIT = 7;
    localparam int unsigned FSL_CFG_RANGE_HI = 6;
    localparam int unsigned FSL_CFG_RANGE_LO = 5;
    localparam int unsigned FSL_CFG_EDGES_HI = 4;
    localparam int unsigned FSL_CFG_EDGES_LO = 3;
    localparam int unsigned FSL_CFG_UPDATE_HI = 2;
    localparam int unsigned FSL_CFG_UPDATE_LO = 0;

    // Timing
    localparam int unsigned FSL_CLK_HZ = 10000000;
    localparam int unsigned FSL_MS_PER_S = 1000;
    localparam int unsigned FSL_CYC_PER_MS = FSL_CLK_HZ / FSL_MS_PER_S;

    // Limit offset per status bit: local, ext1, ext2, ext3
    function automatic logic [7:0] fsl_limit_addr(input int unsigned ch);
        case (ch)
            0: fsl_limit_addr = FSL_ADDR_LIMIT_LOCAL;
            1: fsl_limit_addr = FSL_ADDR_LIMIT_EXT1;
            2: fsl_limit_addr = FSL_ADDR_LIMIT_EXT2;
            default: fsl_limit_addr = FSL_ADDR_LIMIT_EXT3;
        endcase
    endfunction : fsl_limit_addr

    // Update period in milliseconds
    function automatic logic [10:0] fsl_update_ms(input logic [2:0] sel);
        case (sel)
            3'h0: fsl_update_ms = 11'd100;
            3'h1: fsl_update_ms = 11'd200;
            3'h2: fsl_update_ms = 11'd300;
            3'h3: fsl_update_ms = 11'd400;
            3'h4: fsl_update_ms = 11'd500;
            3'h5: fsl_update_ms = 11'd800;
            3'h6: fsl_update_ms = 11'd1200;
            default: fsl_update_ms = 11'd1600;
        endcase
    endfunction : fsl_update_ms

    // Tach count multiplier per range code
    function automatic logic [3:0] fsl_range_mult(input logic [1:0] sel);
        case (sel)
            2'h0: fsl_range_mult = 4'h1;
            2'h1: fsl_range_mult = 4'h2;
            2'h2: fsl_range_mult = 4'h4;
            default: fsl_range_mult = 4'h8;
        endcase
    endfunction : fsl_range_mult

    // Minimum reported rpm per range code
    function automatic logic [12:0] fsl_range_rpm(input logic [1:0] sel);
        case (sel)
            2'h0: fsl_range_rpm = 13'd500;
            2'h1: fsl_range_rpm = 13'd1000;
            2'h2: fsl_range_rpm = 13'd2000;
            default: fsl_range_rpm = 13'd4000;
        endcase
    endfunction : fsl_range_rpm

    // Tach edges per rotation per edges code
    function automatic logic [3:0] fsl_edges(input logic [1:0] sel);
        case (sel)
            2'h0: fsl_edges = 4'h3;
            2'h1: fsl_edges = 4'h5;
            2'h2: fsl_edges = 4'h7;
            default: fsl_edges = 4'h9;
        endcase
    endfunction : fsl_edges

endpackage : fsl_pkg

// ===== logic/fsl_update_timer.sv
// Drive update period timer: one pulse per selected update period
`timescale 1ns/1ps
module fsl_update_timer #(
    parameter int unsigned CYC_PER_MS = fsl_pkg::FSL_CYC_PER_MS
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [2:0] update_sel,
    output logic update_tick
);

    logic [15:0] cyc_reg;
    logic [10:0] ms_reg;
    logic ms_tick;
    logic [10:0] period_ms;

    assign ms_tick = (cyc_reg >= 16'(CYC_PER_MS - 1));
    assign period_ms = fsl_pkg::fsl_update_ms(update_sel);

    // Millisecond prescaler
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            cyc_reg <= 16'h0000;
        else if (ms_tick)
            cyc_reg <= 16'h0000;
        else
            cyc_reg <= cyc_reg + 16'h0001;
    end

    // Period counter; >= so a shorter new period ends at the next millisecond tick
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ms_reg <= 11'h000;
            update_tick <= 1'b0;
        end
        else
        begin
            update_tick <= 1'b0;
            if (ms_tick)
            begin
                if (ms_reg >= period_ms - 11'h001)
                begin
                    ms_reg <= 11'h000;
                    update_tick <= 1'b1;
                end
                else
                    ms_reg <= ms_reg + 11'h001;
            end
        end
    end

endmodule : fsl_update_timer

// ===== logic/fsl_regs.sv
// Fan speed loop register bank: limits, high status, drive setting and loop configuration
`timescale 1ns/1ps
module fsl_regs #(
    parameter int unsigned CYC_PER_MS = fsl_pkg::FSL_CYC_PER_MS
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic sw_lock,
    input wire logic [3:0] int_enable,
    input wire logic [31:0] temp_int,
    input wire logic [7:0] loop_drive,
    input wire logic [7:0] max_step,
    output logic [7:0] fan_drive,
    output logic speed_loop_enable,
    output logic [3:0] tach_multiplier,
    output logic [12:0] tach_min_rpm,
    output logic [3:0] tach_edges,
    output logic update_tick,
    output logic [3:0] high_status,
    output logic high_summary,
    output logic alert_n
);

    logic [7:0] limit_reg [fsl_pkg::FSL_NUM_CH];
    logic [7:0] config_reg;
    logic [7:0] drive_reg;
    logic [3:0] status_reg;
    logic [3:0] over_limit;
    logic [7:0] drive_next;
    logic [7:0] rdata_next;
    logic [7:0] diff;
    logic loop_on;
    logic status_rd;
    logic tick;

    assign loop_on = config_reg[fsl_pkg::FSL_CFG_LOOP_EN_BIT];
    assign status_rd = reg_rd && (reg_addr == fsl_pkg::FSL_ADDR_HIGH_STATUS);

    // Per channel limit register and compare
    for (genvar ch = 0; ch < fsl_pkg::FSL_NUM_CH; ch++)
    begin : g_ch
        always_ff @(posedge mclk or negedge rstn)
        begin
            if (!rstn)
                limit_reg[ch] <= fsl_pkg::FSL_LIMIT_RESET;
            else if (reg_wr && !sw_lock && reg_addr == fsl_pkg::fsl_limit_addr(ch))
                limit_reg[ch] <= reg_wdata;
        end

        assign over_limit[ch] = $signed(temp_int[8*ch +: 8]) >= $signed(limit_reg[ch]);
    end

    // Sticky status; a live condition always wins over the read clear
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            status_reg <= 4'h0;
        else if (status_rd)
            status_reg <= over_limit;
        else
            status_reg <= status_reg | over_limit;
    end

    // Status, summary and alert pins
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            high_status <= 4'h0;
            high_summary <= 1'b0;
            alert_n <= 1'b1;
        end
        else
        begin
            high_status <= status_reg;
            high_summary <= |status_reg;
            alert_n <= ~|(status_reg & int_enable);
        end
    end

    // Configuration register, no lock on it
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            config_reg <= fsl_pkg::FSL_CONFIG_RESET;
        else if (reg_wr && reg_addr == fsl_pkg::FSL_ADDR_FAN_CONFIG)
            config_reg <= reg_wdata;
    end

    // Update period pacing the loop ramp
    fsl_update_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_timer (
        .mclk(mclk),
        .rstn(rstn),
        .update_sel(config_reg[fsl_pkg::FSL_CFG_UPDATE_HI:fsl_pkg::FSL_CFG_UPDATE_LO]),
        .update_tick(tick)
    );

    // Applied drive selection and ramp
    always_comb
    begin
        drive_next = drive_reg;
        diff = 8'h00;
        if (loop_on)
        begin
            if (tick && loop_drive > drive_reg)
            begin
                diff = loop_drive - drive_reg;
                drive_next = drive_reg + ((diff > max_step) ? max_step : diff);
            end
            else if (tick && loop_drive < drive_reg)
            begin
                diff = drive_reg - loop_drive;
                drive_next = drive_reg - ((diff > max_step) ? max_step : diff);
            end
        end
        else if (reg_wr && reg_addr == fsl_pkg::FSL_ADDR_FAN_DRIVE)
            drive_next = reg_wdata;
    end

    // One register is both setting and applied drive
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            drive_reg <= fsl_pkg::FSL_DRIVE_RESET;
        else
            drive_reg <= drive_next;
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        rdata_next = fsl_pkg::FSL_ZERO;
        case (reg_addr)
            fsl_pkg::FSL_ADDR_HIGH_STATUS: rdata_next = {4'h0, status_reg};
            fsl_pkg::FSL_ADDR_LIMIT_LOCAL: rdata_next = limit_reg[0];
            fsl_pkg::FSL_ADDR_LIMIT_EXT1: rdata_next = limit_reg[1];
            fsl_pkg::FSL_ADDR_LIMIT_EXT2: rdata_next = limit_reg[2];
            fsl_pkg::FSL_ADDR_LIMIT_EXT3: rdata_next = limit_reg[3];
            fsl_pkg::FSL_ADDR_FAN_DRIVE: rdata_next = drive_reg;
            fsl_pkg::FSL_ADDR_FAN_CONFIG: rdata_next = config_reg;
            default: rdata_next = fsl_pkg::FSL_ZERO;
        endcase
    end

    // Read data held until the next read
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            reg_rdata <= fsl_pkg::FSL_ZERO;
        else if (reg_rd)
            reg_rdata <= rdata_next;
    end

    // Drive pins; the analog stage scales drive by value/255 of fan supply
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            fan_drive <= fsl_pkg::FSL_DRIVE_RESET;
            speed_loop_enable <= fsl_pkg::FSL_CONFIG_RESET[fsl_pkg::FSL_CFG_LOOP_EN_BIT];
        end
        else
        begin
            fan_drive <= drive_reg;
            speed_loop_enable <= loop_on;
        end
    end

    // Tach scaling pins; only decoded here, the tach counter lives elsewhere
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            tach_multiplier <= fsl_pkg::fsl_range_mult(
                fsl_pkg::FSL_CONFIG_RESET[fsl_pkg::FSL_CFG_RANGE_HI:fsl_pkg::FSL_CFG_RANGE_LO]);
            tach_min_rpm <= fsl_pkg::fsl_range_rpm(
                fsl_pkg::FSL_CONFIG_RESET[fsl_pkg::FSL_CFG_RANGE_HI:fsl_pkg::FSL_CFG_RANGE_LO]);
            tach_edges <= fsl_pkg::fsl_edges(
                fsl_pkg::FSL_CONFIG_RESET[fsl_pkg::FSL_CFG_EDGES_HI:fsl_pkg::FSL_CFG_EDGES_LO]);
        end
        else
        begin
            tach_multiplier <= fsl_pkg::fsl_range_mult(
                config_reg[fsl_pkg::FSL_CFG_RANGE_HI:fsl_pkg::FSL_CFG_RANGE_LO]);
            tach_min_rpm <= fsl_pkg::fsl_range_rpm(
                config_reg[fsl_pkg::FSL_CFG_RANGE_HI:fsl_pkg::FSL_CFG_RANGE_LO]);
            tach_edges <= fsl_pkg::fsl_edges(
                config_reg[fsl_pkg::FSL_CFG_EDGES_HI:fsl_pkg::FSL_CFG_EDGES_LO]);
        end
    end

    // Update pulse re-timed so the pin comes straight from a flop
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            update_tick <= 1'b0;
        else
            update_tick <= tick;
    end

endmodule : fsl_regs

// ===== verif/fsl_regs_assertions.sv
// Port checker for the fan speed loop register bank
`timescale 1ns/1ps
module fsl_regs_assertions (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] int_enable,
    input wire logic [7:0] max_step,
    input wire logic [7:0] fan_drive,
    input wire logic speed_loop_enable,
    input wire logic [3:0] tach_multiplier,
    input wire logic [3:0] tach_edges,
    input wire logic update_tick,
    input wire logic [3:0] high_status,
    input wire logic high_summary,
    input wire logic alert_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // Second cycle guards against a loop enable still in flight
    sequence s_manual_wr;
        reg_wr && reg_addr == 8'h40 && !speed_loop_enable ##1 !speed_loop_enable;
    endsequence
    sequence s_cfg_wr;
        reg_wr && reg_addr == 8'h42;
    endsequence
    // Drive moved while the loop was on for two cycles
    sequence s_loop_move;
        speed_loop_enable && $past(speed_loop_enable) && $changed(fan_drive);
    endsequence

    AST_MANUAL_WR: assert property (s_manual_wr |-> ##1 fan_drive == $past(reg_wdata, 2))
        else $error("manual drive write not applied");
    AST_DRIVE_READ: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == fan_drive)
        else $error("drive read differs from applied drive");
    AST_SUMMARY: assert property (high_summary == |high_status)
        else $error("summary differs from status");
    AST_ALERT_MASK: assert property (alert_n == !(|(high_status & $past(int_enable))))
        else $error("alert does not follow enabled status");
    AST_CFG_SRC: assert property (s_cfg_wr |-> ##2 speed_loop_enable == $past(reg_wdata[7], 2))
        else $error("loop enable not taken from config");
    AST_CFG_DECODE: assert property (s_cfg_wr |-> ##2
        tach_multiplier == 4'h1 << $past(reg_wdata[6:5], 2)
        && tach_edges == 4'h3 + {$past(reg_wdata[4:3], 2), 1'b0})
        else $error("range or edges decode wrong");
    AST_TICK_PULSE: assert property (update_tick |=> !update_tick [*8])
        else $error("update tick not a lone pulse");
    // Jump in loop mode, from a write or a bad step, exceeds the limit in force one cycle back
    AST_STEP_BOUND: assert property (s_loop_move |->
        (fan_drive > $past(fan_drive) ? fan_drive - $past(fan_drive) : $past(fan_drive) - fan_drive)
        <= $past(max_step))
        else $error("loop drive step too large");
endmodule : fsl_regs_assertions

bind fsl_regs fsl_regs_assertions chk_u (.mclk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .int_enable, .max_step, .fan_drive, .speed_loop_enable, .tach_multiplier, .tach_edges, .update_tick,
    .high_status, .high_summary, .alert_n);

// ===== verif/fsl_host_model.sv
// Register host model: one byte access per strobe
`timescale 1ns/1ps
module fsl_host_model (
    input wire logic mclk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // Released address and data lines flip and strobes drop, so stale values never look valid
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk);
        #1;
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(posedge mclk);
        #1;
        q = reg_rdata;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : acc
endmodule : fsl_host_model

// ===== verif/tb_fsl_regs.sv
// Self-checking bench for the fan speed loop register bank
`timescale 1ns/1ps
module tb_fsl_regs;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic sw_lock = 1'b0;
    logic [3:0] int_enable = 4'h0;
    logic [31:0] temp_int = 32'h80808080;
    logic [7:0] loop_drive = 8'h20;
    logic [7:0] max_step = 8'h04;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, fan_drive, q;
    logic reg_wr, reg_rd, speed_loop_enable, update_tick, high_summary, alert_n;
    logic [3:0] tach_multiplier, tach_edges, high_status;
    logic [12:0] tach_min_rpm;
    int bad_count = 0;
    int n_checks = 0;
    int n;
    // Rows: write flag, offset, write data, expected read
    logic [31:0] rows [15] = '{32'h00305555, 32'h00315555, 32'h00325555, 32'h00345555, 32'h00400000,
        32'h0042002b, 32'h00240000, 32'h00500000, 32'h0150aa00, 32'h0124ff00, 32'h0130f6f6,
        32'h01310505, 32'h0134fefe, 32'h01409a9a, 32'h01422b2b};
    int upd_ms [8] = '{100, 200, 300, 400, 500, 800, 1200, 1600};

    always #50 mclk = ~mclk;

    fsl_regs #(.CYC_PER_MS(2)) dut_u (.mclk, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .sw_lock, .int_enable, .temp_int, .loop_drive, .max_step, .fan_drive, .speed_loop_enable,
        .tach_multiplier, .tach_min_rpm, .tach_edges, .update_tick, .high_status, .high_summary, .alert_n);
    fsl_host_model host_u (.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);

    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask : cyc

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Cycles to the next update pulse, bounded
    task automatic wt_tick(output int c);
        c = 0;
        do
        begin
            cyc(1);
            c++;
        end
        while (update_tick !== 1'b1 && c < 4000);
    endtask : wt_tick

    task automatic summarize();
        $display("Checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    initial
    begin
        cyc(50000);
        bad_count++;
        summarize();
    end

    initial
    begin
        cyc(20);
        rstn = 1'b1;
        foreach (rows[i])
        begin
            if (rows[i][24])
                host_u.acc(1'b1, rows[i][23:16], rows[i][15:8], q);
            host_u.acc(1'b0, rows[i][23:16], 8'h00, q);
            chk(q, rows[i][7:0], $sformatf("reg %h", rows[i][23:16]));
        end
        // Signed limits; ch2 trips only if compared unsigned
        temp_int = 32'h00fbf600;
        int_enable = 4'h2;
        cyc(4);
        chk(high_status, 4'h3, "status");
        chk(alert_n, 1'b0, "alert");
        chk(high_summary, 1'b1, "summary");
        int_enable = 4'h0;
        cyc(3);
        chk({high_status, alert_n}, 5'h07, "masked");
        temp_int = 32'h00fbf500;
        cyc(3);
        host_u.acc(1'b0, 8'h24, 8'h00, q);
        chk(q, 8'h03, "status read");
        cyc(3);
        chk(high_status, 4'h1, "status kept");
        sw_lock = 1'b1;
        host_u.acc(1'b1, 8'h30, 8'h00, q);
        host_u.acc(1'b0, 8'h30, 8'h00, q);
        chk(q, 8'hf6, "locked limit");
        sw_lock = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            host_u.acc(1'b1, 8'h42, {1'b0, i[1:0], i[1:0], 3'h3}, q);
            cyc(2);
            chk(tach_multiplier, 4'h1 << i, "mult");
            chk(tach_min_rpm, 13'd500 << i, "rpm");
            // Host rescales its tach target by this edge count
            chk(tach_edges, 4'h3 + 4'(2 * i), "edges");
        end
        // First interval after a change may be short
        for (int k = 0; k < 8; k++)
        begin
            host_u.acc(1'b1, 8'h42, 8'h28 | 8'(k), q);
            wt_tick(n);
            wt_tick(n);
            chk(16'(n), 16'(upd_ms[k] * 2), "period");
        end
        host_u.acc(1'b1, 8'h42, 8'hab, q);
        host_u.acc(1'b1, 8'h40, 8'hff, q);
        wt_tick(n);
        wt_tick(n);
        cyc(3);
        chk(fan_drive, 8'h92, "loop drive");
        chk(speed_loop_enable, 1'b1, "loop enable");
        host_u.acc(1'b0, 8'h40, 8'h00, q);
        chk(q, 8'h92, "drive read");
        host_u.acc(1'b1, 8'h42, 8'h2b, q);
        wt_tick(n);
        cyc(3);
        chk(fan_drive, 8'h92, "held drive");
        chk(speed_loop_enable, 1'b0, "loop disable");
        host_u.acc(1'b1, 8'h40, 8'h5c, q);
        cyc(2);
        chk(fan_drive, 8'h5c, "manual drive");
        // Mid-run reset: every pin and register falls back to its reset value
        rstn = 1'b0;
        cyc(2);
        chk({fan_drive, speed_loop_enable, alert_n}, {8'h00, 1'b0, 1'b1}, "reset drive pins");
        chk(tach_multiplier, 4'h2, "reset mult");
        chk(tach_min_rpm, 13'd1000, "reset rpm");
        chk(tach_edges, 4'h5, "reset edges");
        chk({high_status, high_summary, update_tick}, 6'h00, "reset status");
        rstn = 1'b1;
        host_u.acc(1'b0, 8'h30, 8'h00, q);
        chk(q, 8'h55, "limit after reset");
        host_u.acc(1'b0, 8'h42, 8'h00, q);
        chk(q, 8'h2b, "config after reset");
        summarize();
    end
endmodule : tb_fsl_regs
